/* File: byte_buf_if.sv */
// Valid/ready carrier between the loader and its byte buffer
`timescale 1ns/100ps
interface byte_buf_if;
	import sscfg_pkg::*;
	logic in_valid;
	logic in_ready;
	logic [BYTE_W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [BYTE_W-1:0] out_data;
	modport fifo (input in_valid, input in_data, input out_ready, output in_ready, output out_valid, output out_data);
	modport user (output in_valid, output in_data, output out_ready, input in_ready, input out_valid, input out_data);
endinterface : byte_buf_if

/* File: cfg_byte_buf.sv */
// Two-entry byte buffer with valid and ready on both sides
`timescale 1ns/100ps
module cfg_byte_buf
	import sscfg_pkg::*;
(
	input wire logic mclk, // System clock
	input wire logic arst_n, // Async reset
	input wire logic ce, // Clock enable
	byte_buf_if.fifo bus // Fill and drain sides
);
	logic [BYTE_W-1:0] mem_r [BUF_DEPTH];
	logic [BYTE_W-1:0] mem_nxt [BUF_DEPTH];
	logic wr_r, wr_nxt, rd_r, rd_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;

	// Honest full and empty from the entry count
	assign bus.in_ready = (cnt_r != BUF_FULL);
	assign bus.out_valid = (cnt_r != 2'h0);
	assign bus.out_data = mem_r[rd_r];
	assign push = bus.in_valid && bus.in_ready;
	assign pop = bus.out_valid && bus.out_ready;

	// Next pointers, count and storage
	always_comb begin
		mem_nxt = mem_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wr_r] = bus.in_data;
			wr_nxt = ~wr_r;
		end
		if (pop) begin
			rd_nxt = ~rd_r;
		end
		case ({push, pop})
			2'b10: cnt_nxt = cnt_r + 2'h1;
			2'b01: cnt_nxt = cnt_r - 2'h1;
			default: cnt_nxt = cnt_r;
		endcase
	end

	// Register stage
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mem_r <= '{default: '0};
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			cnt_r <= 2'h0;
		end else if (ce) begin
			mem_r <= mem_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule : cfg_byte_buf

/* File: cfg_source.sv */
// Bitstream source model that also captures the chain output downstream
`timescale 1ns/100ps
module cfg_source (
	input wire logic init_line, // Wired init level
	input wire logic chain_in, // Chain output of the device
	output logic config_clock, // Link clock to the device
	output logic serial_din // Serial data to the device
);
	logic cap[$];
	// Clock stands still low outside frames
	initial begin
		config_clock = 1'b0;
		serial_din = 1'b0;
	end
	// One frame at 80 ns; data is inverted once its hold has passed, so a late sample shows up
	task automatic run(input logic [79:0] pat, input int n);
		int i;
		cap.delete();
		wait (init_line === 1'b1);
		#100;
		for (i = 0; i <= n; i++) begin
			serial_din = (i < n) ? pat[79 - i] : 1'b0; // Set up 40 ns ahead
			#40;
			cap.push_back(chain_in); // Downstream capture at the rise
			config_clock = 1'b1;
			#10;
			serial_din = ~serial_din;
			#30;
			config_clock = 1'b0;
		end
	endtask : run
endmodule : cfg_source

/* File: slave_serial_config_port.sv */
// Slave serial configuration port: bit capture, load counting and chain forwarding
//
// Operation
// - One bitstream bit captured per rising edge.
// - Forward preamble and overflow bits to chain output.
// - Chain output updates on falling config_clock edge.
// - Downstream captures forwarded bit on next rising edge.
// - Mode pins 111 select slave serial loading.
// - Unconnected mode pins read high, default slave.
// - Init line driven open-drain only, wired-AND.
`timescale 1ns/100ps
module slave_serial_config_port
	import sscfg_pkg::*;
(
	input wire logic mclk, // System clock, 200 MHz
	input wire logic arst_n, // Async reset, active low
	input wire logic ce, // Clock enable, freezes state
	input wire logic config_clock, // Configuration clock from source
	input wire logic serial_din, // Serial bitstream input
	input wire logic mode_pin_high, // Mode pin, top bit
	input wire logic mode_pin_mid, // Mode pin, middle bit
	input wire logic mode_pin_low, // Mode pin, low bit
	input wire logic init_i, // Sensed level of init line
	output logic init_o, // Init line drive value, always low
	output logic init_oe, // Init line pulls low while high
	output logic chain_out, // Serial chain output
	output logic [BYTE_W-1:0] cfg_byte, // Loaded configuration byte
	output logic cfg_byte_valid, // Byte available
	input wire logic cfg_byte_ready, // Consumer takes byte
	output logic cfg_done, // Own memory full, forwarding
	output logic cfg_overrun // Byte lost to a stalled consumer
);
	logic [SYNC_W-1:0] sync_r [SYNC_STAGES];
	logic [SYNC_W-1:0] sync_in;
	logic config_clock_rise, config_clock_fall, din_s, init_s;
	logic clk_lvl_r, clk_lvl_nxt, din_prev_r;
	logic [2:0] mode_s;
	cfg_state_e state_r, state_nxt;
	logic [7:0] clr_cnt_r, clr_cnt_nxt;
	logic [15:0] bit_cnt_r, bit_cnt_nxt;
	logic fwd_bit_r, fwd_bit_nxt, fwd_pend_r, fwd_pend_nxt;
	logic chain_out_r, chain_out_nxt;
	logic [BYTE_W-1:0] shift_r, shift_nxt, pend_byte_r, pend_byte_nxt;
	logic pend_valid_r, pend_valid_nxt, overrun_r, overrun_nxt;
	byte_buf_if bbus ();

	// Three-stage synchronisers; only stages two and three are looked at
	assign sync_in = {mode_pin_high, mode_pin_mid, mode_pin_low, init_i, serial_din, config_clock};
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sync_r <= '{default: '0};
			clk_lvl_r <= 1'b0;
			din_prev_r <= 1'b0;
		end else if (ce) begin
			sync_r[0] <= sync_in;
			for (int i = 1; i < SYNC_STAGES; i++) begin
				sync_r[i] <= sync_r[i-1];
			end
			clk_lvl_r <= clk_lvl_nxt;
			din_prev_r <= sync_r[2][SYN_DIN];
		end
	end

	// A clock change counts once stages two and three agree; idle level low, so no edge after reset
	assign clk_lvl_nxt = (sync_r[1][SYN_CLK] == sync_r[2][SYN_CLK]) ? sync_r[2][SYN_CLK] : clk_lvl_r;
	assign config_clock_rise = clk_lvl_nxt && !clk_lvl_r;
	assign config_clock_fall = !clk_lvl_nxt && clk_lvl_r;
	// Data sampled one edge before the clock sample in stage three, so still ahead of the rise
	assign din_s = din_prev_r;
	assign init_s = sync_r[1][SYN_INIT] && sync_r[2][SYN_INIT];
	assign mode_s = sync_r[2][SYN_MODE_HI:SYN_MODE_LO];

	// Main sequencer: clearing, init wait, preamble, load, forward
	always_comb begin
		state_nxt = state_r;
		clr_cnt_nxt = clr_cnt_r;
		bit_cnt_nxt = bit_cnt_r;
		fwd_bit_nxt = fwd_bit_r;
		fwd_pend_nxt = fwd_pend_r;
		chain_out_nxt = chain_out_r;
		shift_nxt = shift_r;
		pend_byte_nxt = pend_byte_r;
		pend_valid_nxt = pend_valid_r;
		overrun_nxt = overrun_r;
		if (pend_valid_r && bbus.in_ready) begin
			pend_valid_nxt = 1'b0;
		end
		unique case (state_r)
			ST_CLEAR: begin
				clr_cnt_nxt = clr_cnt_r + 8'h01;
				// Pins left open read high, so they fall into slave serial
				if (clr_cnt_r == INIT_CLEAR_LAST) begin
					state_nxt = (mode_s == MODE_SLAVE_SERIAL) ? ST_WAIT_INIT : ST_IDLE;
				end
			end
			ST_WAIT_INIT: begin
				// Edges before the wired-AND line goes high are ignored
				if (init_s) begin
					state_nxt = ST_PREAMBLE;
					bit_cnt_nxt = 16'h0000;
				end
			end
			ST_PREAMBLE: begin
				if (config_clock_rise) begin
					fwd_bit_nxt = din_s;
					fwd_pend_nxt = 1'b1;
					bit_cnt_nxt = bit_cnt_r + 16'h0001;
					if (bit_cnt_r == PREAMBLE_BITS - 16'h0001) begin
						state_nxt = ST_LOAD;
						bit_cnt_nxt = 16'h0000;
					end
				end
			end
			ST_LOAD: begin
				if (config_clock_rise) begin
					shift_nxt = {shift_r[BYTE_W-2:0], din_s};
					bit_cnt_nxt = bit_cnt_r + 16'h0001;
					if (bit_cnt_r[2:0] == BYTE_LAST_BIT) begin
						// A stalled consumer may still hold the previous byte
						if (pend_valid_nxt) begin
							overrun_nxt = 1'b1;
						end
						pend_byte_nxt = {shift_r[BYTE_W-2:0], din_s};
						pend_valid_nxt = 1'b1;
					end
					if (bit_cnt_r == CFG_MEM_BITS - 16'h0001) begin
						state_nxt = ST_FORWARD;
					end
				end
			end
			ST_FORWARD: begin
				if (config_clock_rise) begin
					fwd_bit_nxt = din_s;
					fwd_pend_nxt = 1'b1;
				end
			end
			ST_IDLE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_CLEAR;
			end
		endcase
		// Half a clock period later, on the falling edge, the bit goes out
		if (config_clock_fall && fwd_pend_r) begin
			chain_out_nxt = fwd_bit_r;
			fwd_pend_nxt = 1'b0;
		end
	end

	// Register stage of the sequencer
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_CLEAR;
			clr_cnt_r <= 8'h00;
			bit_cnt_r <= 16'h0000;
			fwd_bit_r <= 1'b1;
			fwd_pend_r <= 1'b0;
			chain_out_r <= 1'b1;
			shift_r <= 8'h00;
			pend_byte_r <= 8'h00;
			pend_valid_r <= 1'b0;
			overrun_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			clr_cnt_r <= clr_cnt_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			fwd_bit_r <= fwd_bit_nxt;
			fwd_pend_r <= fwd_pend_nxt;
			chain_out_r <= chain_out_nxt;
			shift_r <= shift_nxt;
			pend_byte_r <= pend_byte_nxt;
			pend_valid_r <= pend_valid_nxt;
			overrun_r <= overrun_nxt;
		end
	end

	// Byte buffer in the data path; with the pending slot a consumer stall of up to three bytes loses nothing
	assign bbus.in_valid = pend_valid_r;
	assign bbus.in_data = pend_byte_r;
	assign bbus.out_ready = cfg_byte_ready;
	cfg_byte_buf u_buf (
		.mclk(mclk),
		.arst_n(arst_n),
		.ce(ce),
		.bus(bbus.fifo)
	);

	// Open-drain init: only ever pulled low, never driven high
	assign init_o = 1'b0;
	assign init_oe = (state_r == ST_CLEAR);
	assign chain_out = chain_out_r;
	assign cfg_byte = bbus.out_data;
	assign cfg_byte_valid = bbus.out_valid;
	assign cfg_done = (state_r == ST_FORWARD);
	assign cfg_overrun = overrun_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_fall_drives_out: assert property (ce && config_clock_fall && fwd_pend_r |=> chain_out_r == $past(fwd_bit_r))
		else $error("chain output missed falling-edge update");
	a_out_only_fall: assert property ($changed(chain_out_r) |-> $past(config_clock_fall) && $past(ce))
		else $error("chain output changed off a falling edge");
	a_out_holds_rise: assert property ($changed(chain_out_r) |=> $stable(chain_out_r) [*3])
		else $error("chain output did not hold for downstream capture");
	a_rise_takes_bit: assert property (ce && config_clock_rise && state_r == ST_FORWARD |=> fwd_pend_r && fwd_bit_r == $past(din_s))
		else $error("rising edge did not capture input bit");
	a_preamble_forward: assert property (ce && config_clock_rise && state_r == ST_PREAMBLE |=> fwd_pend_r)
		else $error("preamble bit not queued for forwarding");
	a_load_no_forward: assert property (ce && config_clock_rise && state_r == ST_LOAD |=> !fwd_pend_r)
		else $error("loaded bit was forwarded");
	a_mode_select: assert property (ce && state_r == ST_CLEAR && clr_cnt_r == INIT_CLEAR_LAST && mode_s == MODE_SLAVE_SERIAL |=> state_r == ST_WAIT_INIT)
		else $error("mode 111 did not select slave serial");
	a_mode_other: assert property (ce && state_r == ST_CLEAR && clr_cnt_r == INIT_CLEAR_LAST && mode_s != MODE_SLAVE_SERIAL |=> state_r == ST_IDLE)
		else $error("non-slave mode started loading");
	a_init_released: assert property (state_r != ST_CLEAR |-> !init_oe && !init_o)
		else $error("init line pulled after clearing");
	a_count_full: assert property (ce && config_clock_rise && state_r == ST_LOAD && bit_cnt_r == CFG_MEM_BITS - 16'h0001 |=> state_r == ST_FORWARD)
		else $error("load count did not end at memory size");
	a_wait_init: assert property (ce && state_r == ST_WAIT_INIT && !init_s |=> state_r == ST_WAIT_INIT)
		else $error("started before init line went high");

	c_load_done: cover property (state_r == ST_LOAD ##1 state_r == ST_FORWARD);
	c_byte_out: cover property (cfg_byte_valid && cfg_byte_ready);
	c_fwd_bit: cover property (state_r == ST_FORWARD && $changed(chain_out_r));
	c_stall_full: cover property (cfg_byte_valid && !cfg_byte_ready && !bbus.in_ready);
endmodule : slave_serial_config_port

/* File: sscfg_pkg.sv */
// Constants and types shared by the slave serial configuration port
package sscfg_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int INIT_CLEAR_NS = 1000;
	// Least time, so round up to whole cycles
	localparam int INIT_CLEAR_CYC = (INIT_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] INIT_CLEAR_LAST = 8'(INIT_CLEAR_CYC - 1);
	localparam int SYNC_STAGES = 3;
	localparam int SYNC_W = 6;
	localparam int SYN_CLK = 0;
	localparam int SYN_DIN = 1;
	localparam int SYN_INIT = 2;
	localparam int SYN_MODE_LO = 3;
	localparam int SYN_MODE_HI = 5;
	localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h7;
	localparam logic [15:0] PREAMBLE_BITS = 16'h0008;
	localparam logic [15:0] CFG_MEM_BITS = 16'h0040;
	localparam int BYTE_W = 8;
	localparam int BUF_DEPTH = 2;
	localparam logic [1:0] BUF_FULL = 2'h2;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	typedef enum logic [5:0] {
		ST_CLEAR = 6'h01,
		ST_WAIT_INIT = 6'h02,
		ST_PREAMBLE = 6'h04,
		ST_LOAD = 6'h08,
		ST_FORWARD = 6'h10,
		ST_IDLE = 6'h20
	} cfg_state_e;
endpackage : sscfg_pkg

/* File: test_slave_serial_config_port.sv */
// Testbench for the slave serial configuration port
`timescale 1ns/100ps
module test_slave_serial_config_port
	import sscfg_pkg::*;
;
	localparam logic [79:0] PAT = 80'hc3a5_0f96_1e2d_b478_e1f0;
	logic mclk, arst_n, config_clock, serial_din, init_i, init_o, init_oe, chain_out;
	logic mode_oe;
	logic ce;
	logic [2:0] mode_drv;
	logic [2:0] mode_pins;
	logic [BYTE_W-1:0] cfg_byte;
	logic cfg_byte_valid, cfg_byte_ready, cfg_done, cfg_overrun;
	logic [BYTE_W-1:0] got[$];
	int fail_count, checked, cycles;
	// Weak pull-ups win while the bench leaves the pins open
	assign mode_pins = mode_oe ? mode_drv : 3'h7;
	// Open-drain init line with a pull-up
	assign init_i = !(init_oe === 1'b1 && init_o === 1'b0);
	slave_serial_config_port u_dut (.mclk(mclk), .arst_n(arst_n), .ce(ce), .config_clock(config_clock),
		.serial_din(serial_din), .mode_pin_high(mode_pins[2]), .mode_pin_mid(mode_pins[1]),
		.mode_pin_low(mode_pins[0]), .init_i(init_i), .init_o(init_o), .init_oe(init_oe),
		.chain_out(chain_out), .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid),
		.cfg_byte_ready(cfg_byte_ready), .cfg_done(cfg_done), .cfg_overrun(cfg_overrun));
	cfg_source u_src (.init_line(init_i), .chain_in(chain_out), .config_clock(config_clock),
		.serial_din(serial_din));
	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Byte consumer and hang guard
	always @(posedge mclk) begin
		if (cfg_byte_valid === 1'b1 && cfg_byte_ready === 1'b1)
			got.push_back(cfg_byte);
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			give_verdict();
		end
	end
	task check(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t: %s", $time, msg);
		end
	endtask : check
	task give_verdict();
		$display("Checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	// Reset with given mode pins, optional clock-enable freeze, then watch the init line clear
	task do_reset(input logic [2:0] m, input logic oe, input int hold);
		@(posedge mclk);
		#1;
		arst_n = 1'b0;
		mode_drv = m;
		mode_oe = oe;
		cfg_byte_ready = 1'b1;
		repeat (10) @(posedge mclk);
		#1;
		check(init_oe === 1'b1 && init_o === 1'b0 && chain_out === 1'b1, "reset outputs");
		check(cfg_byte_valid === 1'b0 && cfg_done === 1'b0 && cfg_overrun === 1'b0, "reset flags");
		arst_n = 1'b1;
		// Clearing must not advance while the enable is low
		if (hold > 0) begin
			ce = 1'b0;
			repeat (hold) @(posedge mclk);
			#1;
			ce = 1'b1;
		end
		repeat (195) @(posedge mclk);
		#1;
		check(init_oe === 1'b1, "init released early");
		repeat (10) @(posedge mclk);
		#1;
		check(init_oe === 1'b0, "init not released");
		got.delete();
	endtask : do_reset
	// Open mode pins, full frame, consumer stalls until the buffer and pending slot fill
	task t_load_chain();
		int i;
		logic exp;
		do_reset(3'h0, 1'b0, 0);
		cfg_byte_ready = 1'b0;
		fork
			u_src.run(PAT, 80);
			begin
				wait (cfg_byte_valid === 1'b1);
				repeat (300) @(posedge mclk);
				#1;
				check(cfg_byte === PAT[71 -: 8], "first byte not held");
				cfg_byte_ready = 1'b1;
			end
		join
		repeat (8) @(posedge mclk);
		#1;
		check(got.size() == 8 && cfg_done === 1'b1 && cfg_overrun === 1'b0, "load end");
		for (i = 0; i < 8 && i < got.size(); i++)
			check(got[i] === PAT[71 - 8 * i -: 8], "byte data");
		for (i = 0; i < 80; i++) begin
			exp = (i >= 8 && i < 72) ? PAT[72] : PAT[79 - i];
			check(u_src.cap[i + 1] === exp, "chain bit");
		end
		$display("Test load_chain done");
	endtask : t_load_chain
	// A driven mode other than all ones leaves the port idle
	task t_wrong_mode();
		int i;
		do_reset(3'h6, 1'b1, 0);
		u_src.run(PAT, 16);
		repeat (8) @(posedge mclk);
		#1;
		check(got.size() == 0 && cfg_done === 1'b0, "idle mode loaded");
		for (i = 0; i <= 16; i++)
			check(u_src.cap[i] === 1'b1, "idle mode forwarded");
		$display("Test wrong_mode done");
	endtask : t_wrong_mode
	// Driven 111, clearing frozen a while, consumer stalled until after the load: the pending byte is overwritten
	task t_overrun();
		do_reset(3'h7, 1'b1, 40);
		cfg_byte_ready = 1'b0;
		u_src.run(PAT, 72);
		repeat (8) @(posedge mclk);
		#1;
		check(cfg_overrun === 1'b1 && cfg_done === 1'b1 && got.size() == 0, "overrun not flagged");
		check(cfg_byte_valid === 1'b1 && cfg_byte === PAT[71 -: 8], "stalled byte lost");
		cfg_byte_ready = 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		check(got.size() == 3 && got[1] === PAT[63 -: 8] && got[2] === PAT[15 -: 8], "drain after overrun");
		$display("Test overrun done");
	endtask : t_overrun
	// Main sequence
	initial begin
		arst_n = 1'b0;
		mode_drv = 3'h0;
		mode_oe = 1'b0;
		ce = 1'b1;
		cfg_byte_ready = 1'b0;
		fail_count = 0;
		checked = 0;
		cycles = 0;
		t_load_chain();
		t_wrong_mode();
		t_overrun();
		give_verdict();
	end
endmodule : test_slave_serial_config_port
